// ==== bench/mmio_region_decode_tb.sv ====
// self-checking bench of the address-region decoder
`timescale 1ns/1ps
`default_nettype none
module mmio_region_decode_tb;
	import region_decode_pkg::*;
	logic clk, rst_n, av_rd, av_wr, av_wait;
	logic [BUS_AW-1:0] av_addr;
	logic [BUS_W-1:0] av_wd, av_rdata;
	logic [3:0] av_be;
	logic req_v, req_unc, req_unc_acc, req_coh, req_wr;
	logic [ADDR_W-1:0] req_addr;
	logic r_valid, r_hit, r_err, r_byp, r_coh;
	logic [0:0] r_region;
	logic [PORT_W-1:0] r_port;
	logic [1:0] r_cmd;
	logic [31:0] taken, side;
	int fails, compares, cycles, sent, exp_side;
	// ************************************************************
	// design and far side
	// ************************************************************
	mmio_region_decode #(
		.REGIONS(2),
		.LOWER_RESET({64'hFFFF_1234_5678_FFFF, 64'h0000_0000_0000_0000}),
		.UPPER_RESET({64'h0000_0000_0000_0000, 64'hFFFF_ABCD_0123_FFFF})
	) mmio_region_decode_inst (
		.SYS_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(av_addr),
		.AVS_READ_I(av_rd), .AVS_WRITE_I(av_wr), .AVS_WRITEDATA_I(av_wd),
		.AVS_BYTEENABLE_I(av_be), .AVS_READDATA_O(av_rdata),
		.AVS_WAITREQUEST_O(av_wait), .REQ_VALID_I(req_v),
		.REQ_ADDR_I(req_addr), .REQ_UNCACHED_I(req_unc),
		.REQ_UNCACHED_ACCEL_I(req_unc_acc), .REQ_COHERENT_I(req_coh),
		.REQ_WRITE_I(req_wr), .ROUTE_VALID_O(r_valid), .ROUTE_HIT_O(r_hit),
		.ROUTE_REGION_O(r_region), .ROUTE_PORT_O(r_port),
		.ROUTE_PORT_ERR_O(r_err), .ROUTE_BYPASS_LIMIT_O(r_byp),
		.ROUTE_COHERENT_O(r_coh), .ROUTE_ACE_CMD_O(r_cmd)
	);
	route_sink route_sink_inst (
		.clk_i(clk), .rst_n_i(rst_n), .valid_i(r_valid), .hit_i(r_hit),
		.port_i(r_port), .taken_o(taken), .side_o(side)
	);
	// ************************************************************
	// clock, timeout and report
	// ************************************************************
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic final_report();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			final_report();
		end
	end
	task automatic chk(input string what, input logic [63:0] exp,
		input logic [63:0] got);
		compares++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
			fails++;
		end
	endtask
	// ************************************************************
	// register bus
	// ************************************************************
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		av_addr <= a;
		av_wd <= d;
		av_wr <= wr;
		av_rd <= ~wr;
		do @(posedge clk); while (av_wait !== 1'b0);
		q = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
	endtask
	task automatic wr64(input logic [11:0] a, input logic [63:0] v);
		logic [31:0] q;
		bus(1'b1, a, v[31:0], q);
		bus(1'b1, a + 12'h4, v[63:32], q);
	endtask
	task automatic rd64(input logic [11:0] a, input logic [63:0] exp);
		logic [31:0] lo, hi;
		bus(1'b0, a, 32'h0, lo);
		bus(1'b0, a + 12'h4, 32'h0, hi);
		chk($sformatf("reg %0h", a), exp, {hi, lo});
	endtask
	// ************************************************************
	// requests
	// ************************************************************
	task automatic send(input logic [31:0] hi, input logic [1:0] attr,
		input logic coh, input logic wr);
		@(posedge clk);
		req_v <= 1'b1;
		req_addr <= {hi, 16'hA5C3};
		req_unc <= attr[0];
		req_unc_acc <= attr[1];
		req_coh <= coh;
		req_wr <= wr;
		@(posedge clk);
		req_v <= 1'b0;
		@(negedge clk);
		sent++;
	endtask
	task automatic expect_route(input string what, input logic hit,
		input logic rg, input logic [3:0] p, input logic err,
		input logic byp, input logic coh, input logic [1:0] cmd);
		if (hit && p >= PORT_SIDE_FIRST)
			exp_side++;
		chk(what, {1'b1, hit, rg, p, err, byp, coh, cmd},
			{r_valid, r_hit, r_region, r_port, r_err, r_byp, r_coh, r_cmd});
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_regs();
		logic [31:0] q;
		rd64(12'h700, 64'h0);
		rd64(12'h708, 64'h0000_ABCD_0123_0000);
		rd64(12'h710, 64'h0000_1234_5678_037F);
		for (int i = 0; i < 4; i++)
		begin
			wr64(12'h700 + 12'(8 * i), 64'hFFFF_FFFF_FFFF_FFFF);
			rd64(12'h700 + 12'(8 * i), i % 2 ? UPPER_WMASK : LOWER_WMASK);
		end
		// single byte lane write keeps the other lanes
		av_be <= 4'h2;
		bus(1'b1, 12'h700, 32'h0, q);
		av_be <= BE_ALL;
		rd64(12'h700, 64'h0000_FFFF_FFFF_007F);
		wr64(12'h720, 64'hFFFF_FFFF_FFFF_FFFF);
		rd64(12'h720, 64'h0);
		rd64(12'h7F0, 64'h0);
		$display("test registers done");
	endtask
	task automatic t_bounds();
		logic [31:0] a [4] = '{32'hF, 32'h10, 32'h20, 32'h21};
		wr64(12'h710, 64'h0);
		wr64(12'h700, 64'h0000_0000_0010_0001);
		wr64(12'h708, 64'h0000_0000_0020_0000);
		for (int i = 0; i < 4; i++)
		begin
			send(a[i], 2'b00, 1'b0, 1'b1);
			expect_route("bounds", i == 1 || i == 2, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 2'b11);
		end
		$display("test bounds done");
	endtask
	task automatic t_enable();
		wr64(12'h700, 64'h0000_0000_0010_0000);
		wr64(12'h710, 64'h0000_0000_0018_0021);
		wr64(12'h718, 64'h0000_0000_0018_0000);
		send(32'h18, 2'b00, 1'b0, 1'b0);
		expect_route("region one", 1'b1, 1'b1, 4'h8, 1'b0, 1'b0, 1'b0, 2'b10);
		send(32'h17, 2'b00, 1'b0, 1'b0);
		expect_route("disabled", 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 2'b10);
		wr64(12'h710, 64'h0);
		send(32'h18, 2'b00, 1'b0, 1'b0);
		expect_route("all disabled", 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 2'b10);
		$display("test enable done");
	endtask
	task automatic t_qual();
		logic [31:0] q;
		for (int qu = 0; qu < 4; qu++)
			for (int at = 0; at < 3; at++)
			begin
				bus(1'b1, 12'h700, {16'h0010, 6'h00, 2'(qu), 8'h01}, q);
				send(32'h10, 2'(at), 1'b0, 1'b0);
				expect_route("qualifier", qu == 0 || (qu[0] && at == 1) ||
					(qu[1] && at == 2), 1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 2'b10);
			end
		$display("test qualifier done");
	endtask
	task automatic t_port();
		logic [31:0] q;
		logic ok;
		for (int p = 0; p < 16; p++)
		begin
			ok = p == 0 || (p >= 8 && p <= 11);
			bus(1'b1, 12'h700, {16'h0010, 10'h000, 4'(p), 2'b01}, q);
			send(32'h1F, 2'b00, 1'b0, 1'b0);
			expect_route("port", ok, 1'b0, 4'(p), ~ok, 1'b0, 1'b0, 2'b10);
		end
		$display("test port done");
	endtask
	task automatic t_noncoh();
		logic [31:0] q;
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b1, 12'h700, {16'h0010, 9'h000, i[2], 4'h0, i[1], 1'b1}, q);
			send(32'h12, 2'b01, 1'b1, i[0]);
			expect_route("forced", 1'b1, 1'b0, 4'h0, 1'b0, i[1], ~i[2], {i[2], i[0]});
			send(32'h30, 2'b01, 1'b1, i[0]);
			expect_route("miss", 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, 1'b1, {1'b0, i[0]});
		end
		$display("test coherence done");
	endtask
	initial
	begin
		rst_n = 1'b0;
		{av_rd, av_wr, req_v, req_unc, req_unc_acc, req_coh, req_wr} = '0;
		av_addr = '0;
		av_wd = '0;
		av_be = BE_ALL;
		req_addr = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_bounds();
		t_enable();
		t_qual();
		t_port();
		t_noncoh();
		repeat (2) @(posedge clk);
		chk("sink count", 64'(sent), {32'h0, taken});
		chk("side count", 64'(exp_side), {32'h0, side});
		final_report();
	end
endmodule
`default_nettype wire

// ==== bench/route_sink.sv ====
// far-side sink that takes routed requests
`timescale 1ns/1ps
`default_nettype none
module route_sink
	import region_decode_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// routed request
	input wire logic valid_i,
	input wire logic hit_i,
	input wire logic [PORT_W-1:0] port_i,
	// accepted counts
	output logic [31:0] taken_o,
	output logic [31:0] side_o
);
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			taken_o <= 32'h0;
			side_o <= 32'h0;
		end
		else if (valid_i)
		begin
			taken_o <= taken_o + 32'h1;
			if (hit_i && port_i >= PORT_SIDE_FIRST)
				side_o <= side_o + 32'h1;
		end
	end
endmodule
`default_nettype wire

// ==== design/mmio_region_decode.sv ====
// address-region decoder with limit registers on an Avalon-MM slave
// Operation
// - region 0 upper register keeps highest region address in bits 47:16
// - region n registers exist only when region count exceeds n
// - region 0 lower register keeps lowest address in 47:16, controls below
// - upper limit pairs with lower limit to bound region 0
// - qualifier 00 means hit depends on address only
// - qualifier 01 uncached, 10 uncached-accelerated, 11 either
// - force-non-coherent bit makes coherent requests of region non-coherent
// - forced requests leave as ReadNoSnoop or WriteNoSnoop
// - port field 0 main, 8..11 side ports, others reserved
// - bit 0 enables region; disabled region never hits
// - bit 1 exempts region from request limit policy
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none
module mmio_region_decode
	import region_decode_pkg::*;
#(
	parameter int REGIONS = 2,
	parameter int RIDX_W = (REGIONS > 1) ? $clog2(REGIONS) : 1,
	parameter logic [REGIONS-1:0][REG_W-1:0] LOWER_RESET = '0,
	parameter logic [REGIONS-1:0][REG_W-1:0] UPPER_RESET = '0
)
(
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_N_I,
	// register bus
	input wire logic [BUS_AW-1:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [BUS_W-1:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [BUS_W-1:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// request to classify
	input wire logic REQ_VALID_I,
	input wire logic [ADDR_W-1:0] REQ_ADDR_I,
	input wire logic REQ_UNCACHED_I,
	input wire logic REQ_UNCACHED_ACCEL_I,
	input wire logic REQ_COHERENT_I,
	input wire logic REQ_WRITE_I,
	// routing result
	output logic ROUTE_VALID_O,
	output logic ROUTE_HIT_O,
	output logic [RIDX_W-1:0] ROUTE_REGION_O,
	output logic [PORT_W-1:0] ROUTE_PORT_O,
	output logic ROUTE_PORT_ERR_O,
	output logic ROUTE_BYPASS_LIMIT_O,
	output logic ROUTE_COHERENT_O,
	output logic [1:0] ROUTE_ACE_CMD_O
);

	// ************************************************************
	// types
	// ************************************************************
	typedef struct packed {
		logic [REGIONS-1:0][REG_W-1:0] lower;
		logic [REGIONS-1:0][REG_W-1:0] upper;
		logic wreq;
		logic [BUS_W-1:0] rdata;
		logic rvalid;
		logic rhit;
		logic [RIDX_W-1:0] rregion;
		logic [PORT_W-1:0] rport;
		logic rerr;
		logic rbypass;
		logic rcoh;
		ace_cmd_e racmd;
	} state_s;

	typedef struct packed {
		logic ok;
		logic status;
		logic [RIDX_W-1:0] idx;
		logic upper;
		logic hi;
	} dec_s;

	state_s q;
	state_s d;
	logic [REGIONS-1:0] hit_w;
	logic [REGIONS-1:0] en_w;
	dec_s dw;

	// ************************************************************
	// functions
	// ************************************************************
	function automatic dec_s decode(input logic [BUS_AW-1:0] a);
		logic [BUS_AW-1:0] rel;
		dec_s r;
		rel = a - REGION_BASE;
		r = '0;
		r.status = (a[BUS_AW-1:2] == STATUS_OFS[BUS_AW-1:2]);
		r.upper = rel[UPPER_BIT];
		r.hi = rel[HI_WORD_BIT];
		r.idx = RIDX_W'(rel >> REGION_SHIFT);
		// absent regions decode as unmapped
		r.ok = (a >= REGION_BASE) && ((rel >> REGION_SHIFT) < REGIONS);
		return r;
	endfunction

	function automatic logic port_legal(input logic [PORT_W-1:0] p);
		return (p == PORT_MAIN) ||
			((p >= PORT_SIDE_FIRST) && (p <= PORT_SIDE_LAST));
	endfunction

	// merge one bus word into a 64-bit register under byte enables
	function automatic logic [REG_W-1:0] wr64(
		input logic [REG_W-1:0] old,
		input logic [REG_W-1:0] mask,
		input logic hi,
		input logic [3:0] be,
		input logic [BUS_W-1:0] wd
	);
		logic [BUS_W-1:0] w;
		logic [REG_W-1:0] full;
		w = hi ? old[REG_W-1:BUS_W] : old[BUS_W-1:0];
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				w[b*8 +: 8] = wd[b*8 +: 8];
		end
		full = hi ? {w, old[BUS_W-1:0]} : {old[REG_W-1:BUS_W], w};
		// reserved bits never take a write
		return (old & ~mask) | (full & mask);
	endfunction

	// ************************************************************
	// per-region matchers
	// ************************************************************
	for (genvar g = 0; g < REGIONS; g++)
	begin : g_region
		region_if rif ();
		assign rif.en = q.lower[g][EN_BIT];
		assign rif.qual = qual_e'(q.lower[g][QUAL_LSB +: QUAL_W]);
		assign rif.lo = q.lower[g][LIMIT_LSB +: LIMIT_W];
		assign rif.hi = q.upper[g][LIMIT_LSB +: LIMIT_W];
		assign rif.addr_hi = REQ_ADDR_I[LIMIT_LSB +: LIMIT_W];
		assign rif.uncached = REQ_UNCACHED_I;
		assign rif.uncached_accel = REQ_UNCACHED_ACCEL_I;
		assign hit_w[g] = rif.hit;
		assign en_w[g] = rif.en;
		region_match u_match (
			.rif(rif)
		);
	end

	// ************************************************************
	// next state
	// ************************************************************
	assign dw = decode(AVS_ADDRESS_I);
	always_comb
	begin
		logic [BUS_W-1:0] rd;
		logic [REG_W-1:0] rv;
		logic found;
		logic [RIDX_W-1:0] sel;
		logic [PORT_W-1:0] port;
		logic noncoh;
		rd = '0;
		rv = '0;
		found = 1'b0;
		sel = '0;
		port = PORT_MAIN;
		noncoh = 1'b0;
		d = q;

		// read mux; unmapped words read zero
		if (dw.status)
		begin
			rd[ST_VALID_BIT] = q.rvalid;
			rd[ST_HIT_BIT] = q.rhit;
			rd[ST_ERR_BIT] = q.rerr;
			rd[ST_COH_BIT] = q.rcoh;
			rd[ST_PORT_LSB +: PORT_W] = q.rport;
			rd[ST_REGION_LSB +: RIDX_W] = q.rregion;
		end
		else if (dw.ok)
		begin
			rv = dw.upper ? q.upper[dw.idx] : q.lower[dw.idx];
			rd = dw.hi ? rv[REG_W-1:BUS_W] : rv[BUS_W-1:0];
		end

		// one wait cycle, then answer
		if ((AVS_READ_I || AVS_WRITE_I) && q.wreq)
		begin
			d.wreq = 1'b0;
			d.rdata = rd;
		end
		else
		begin
			d.wreq = 1'b1;
			if (AVS_WRITE_I && !q.wreq && dw.ok)
			begin
				if (dw.upper)
					d.upper[dw.idx] = wr64(q.upper[dw.idx], UPPER_WMASK,
						dw.hi, AVS_BYTEENABLE_I, AVS_WRITEDATA_I);
				else
					d.lower[dw.idx] = wr64(q.lower[dw.idx], LOWER_WMASK,
						dw.hi, AVS_BYTEENABLE_I, AVS_WRITEDATA_I);
			end
		end

		// lowest numbered region wins
		for (int i = REGIONS - 1; i >= 0; i--)
		begin
			if (hit_w[i])
			begin
				found = 1'b1;
				sel = RIDX_W'(i);
			end
		end
		if (found)
			port = q.lower[sel][PORT_LSB +: PORT_W];

		d.rvalid = REQ_VALID_I;
		d.rhit = REQ_VALID_I && found && port_legal(port);
		d.rerr = REQ_VALID_I && found && !port_legal(port);
		d.rregion = sel;
		d.rport = port;
		d.rbypass = d.rhit && q.lower[sel][BYPASS_BIT];
		noncoh = d.rhit && q.lower[sel][NONCOH_BIT];
		d.rcoh = REQ_VALID_I && REQ_COHERENT_I && !noncoh;
		d.racmd = ace_cmd_e'({!d.rcoh, REQ_WRITE_I});
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			q <= '0;
			q.wreq <= 1'b1;
			for (int i = 0; i < REGIONS; i++)
			begin
				q.lower[i] <= LOWER_RESET[i] & LOWER_WMASK;
				q.upper[i] <= UPPER_RESET[i] & UPPER_WMASK;
			end
		end
		else
			q <= d;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign AVS_READDATA_O = q.rdata;
	assign AVS_WAITREQUEST_O = q.wreq;
	assign ROUTE_VALID_O = q.rvalid;
	assign ROUTE_HIT_O = q.rhit;
	assign ROUTE_REGION_O = q.rregion;
	assign ROUTE_PORT_O = q.rport;
	assign ROUTE_PORT_ERR_O = q.rerr;
	assign ROUTE_BYPASS_LIMIT_O = q.rbypass;
	assign ROUTE_COHERENT_O = q.rcoh;
	assign ROUTE_ACE_CMD_O = q.racmd;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	property p_wait_answer;
		((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O)
			|=> !AVS_WAITREQUEST_O;
	endproperty
	a_wait_answer: assert property (p_wait_answer)
		else $error("bus request not answered after one wait cycle");
	property p_wait_release;
		!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O;
	endproperty
	a_wait_release: assert property (p_wait_release)
		else $error("waitrequest low for more than one cycle");
	property p_upper_write;
		(AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I == BE_ALL
			&& AVS_ADDRESS_I == REG0_UPPER_LO)
		|=> (q.upper[0][BUS_W-1:LIMIT_LSB] ==
			$past(AVS_WRITEDATA_I[BUS_W-1:LIMIT_LSB]))
			&& (q.upper[0][LIMIT_LSB-1:0] == '0);
	endproperty
	a_upper_write: assert property (p_upper_write)
		else $error("upper limit field not stored as written");
	if (REGIONS > 1)
	begin : g_r1chk
		property p_lower_write;
			(AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I == BE_ALL
				&& AVS_ADDRESS_I == REG1_LOWER_LO)
			|=> q.lower[1][BUS_W-1:0] ==
				($past(AVS_WRITEDATA_I) & LOWER_WMASK[BUS_W-1:0]);
		endproperty
		a_lower_write: assert property (p_lower_write)
			else $error("region 1 lower word not stored as written");
	end
	property p_range;
		(ROUTE_HIT_O && ROUTE_REGION_O == '0)
		|-> ($past(REQ_ADDR_I[LIMIT_LSB +: LIMIT_W]) >=
			$past(q.lower[0][LIMIT_LSB +: LIMIT_W]))
			&& ($past(REQ_ADDR_I[LIMIT_LSB +: LIMIT_W]) <=
			$past(q.upper[0][LIMIT_LSB +: LIMIT_W]));
	endproperty
	a_range: assert property (p_range)
		else $error("region 0 hit outside its limits");
	property p_addr_only;
		(REQ_VALID_I && q.lower[0][EN_BIT]
			&& q.lower[0][QUAL_LSB +: QUAL_W] == QUAL_ANY
			&& port_legal(q.lower[0][PORT_LSB +: PORT_W])
			&& REQ_ADDR_I[LIMIT_LSB +: LIMIT_W] >= q.lower[0][LIMIT_LSB +: LIMIT_W]
			&& REQ_ADDR_I[LIMIT_LSB +: LIMIT_W] <= q.upper[0][LIMIT_LSB +: LIMIT_W])
		|=> ROUTE_HIT_O && ROUTE_REGION_O == '0;
	endproperty
	a_addr_only: assert property (p_addr_only)
		else $error("address-only region 0 did not hit");
	property p_qual_uncached;
		(ROUTE_HIT_O && ROUTE_REGION_O == '0
			&& $past(q.lower[0][QUAL_LSB +: QUAL_W]) == QUAL_UNCACHED)
		|-> $past(REQ_UNCACHED_I);
	endproperty
	a_qual_uncached: assert property (p_qual_uncached)
		else $error("uncached-only region hit by other attribute");
	property p_disabled;
		(REQ_VALID_I && en_w == '0) |=> (ROUTE_VALID_O && !ROUTE_HIT_O);
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("hit with every region disabled");
	property p_noncoh;
		(ROUTE_HIT_O && ROUTE_REGION_O == '0
			&& $past(q.lower[0][NONCOH_BIT]))
		|-> !ROUTE_COHERENT_O && ROUTE_ACE_CMD_O[ACE_NOSNOOP_BIT];
	endproperty
	a_noncoh: assert property (p_noncoh)
		else $error("forced region request left as snooping");
	property p_port;
		ROUTE_HIT_O |-> port_legal(ROUTE_PORT_O) && !ROUTE_PORT_ERR_O;
	endproperty
	a_port: assert property (p_port)
		else $error("hit routed to reserved port");
	property p_bypass;
		(ROUTE_HIT_O && ROUTE_REGION_O == '0)
		|-> ROUTE_BYPASS_LIMIT_O == $past(q.lower[0][BYPASS_BIT]);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("limit bypass does not follow region 0");
	property p_reserved;
		(AVS_READ_I && !AVS_WAITREQUEST_O && dw.ok && dw.hi)
		|-> AVS_READDATA_O[BUS_W-1:LIMIT_LSB] == '0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved upper bits read nonzero");
	property p_absent;
		(AVS_READ_I && !AVS_WAITREQUEST_O && !dw.ok && !dw.status)
		|-> AVS_READDATA_O == '0;
	endproperty
	a_absent: assert property (p_absent)
		else $error("unmapped or absent register read nonzero");

endmodule
`default_nettype wire

// ==== design/region_decode_pkg.sv ====
// shared constants and types for the address-region decoder
package region_decode_pkg;

	// ************************************************************
	// request and limit geometry
	// ************************************************************
	localparam int ADDR_W = 48;
	localparam int LIMIT_LSB = 16;
	localparam int LIMIT_W = 32;
	localparam int REG_W = 64;
	localparam int BUS_W = 32;
	localparam int BUS_AW = 12;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [BUS_AW-1:0] REGION_BASE = 12'h700;
	localparam logic [BUS_AW-1:0] REG0_UPPER_LO = 12'h708;
	localparam logic [BUS_AW-1:0] REG1_LOWER_LO = 12'h710;
	localparam logic [BUS_AW-1:0] STATUS_OFS = 12'h780;
	localparam int REGION_SHIFT = 4;
	localparam int UPPER_BIT = 3;
	localparam int HI_WORD_BIT = 2;
	localparam logic [3:0] BE_ALL = 4'hF;

	// ************************************************************
	// field layout of the limit registers
	// ************************************************************
	localparam int EN_BIT = 0;
	localparam int BYPASS_BIT = 1;
	localparam int PORT_LSB = 2;
	localparam int PORT_W = 4;
	localparam int NONCOH_BIT = 6;
	localparam int QUAL_LSB = 8;
	localparam int QUAL_W = 2;
	localparam logic [REG_W-1:0] LOWER_WMASK = 64'h0000_FFFF_FFFF_037F;
	localparam logic [REG_W-1:0] UPPER_WMASK = 64'h0000_FFFF_FFFF_0000;

	// ************************************************************
	// status word layout
	// ************************************************************
	localparam int ST_VALID_BIT = 0;
	localparam int ST_HIT_BIT = 1;
	localparam int ST_ERR_BIT = 2;
	localparam int ST_COH_BIT = 3;
	localparam int ST_PORT_LSB = 4;
	localparam int ST_REGION_LSB = 8;

	// ************************************************************
	// encodings
	// ************************************************************
	localparam logic [PORT_W-1:0] PORT_MAIN = 4'h0;
	localparam logic [PORT_W-1:0] PORT_SIDE_FIRST = 4'h8;
	localparam logic [PORT_W-1:0] PORT_SIDE_LAST = 4'hB;
	localparam int ACE_NOSNOOP_BIT = 1;

	typedef enum logic [1:0] {
		QUAL_ANY = 2'b00,
		QUAL_UNCACHED = 2'b01,
		QUAL_UNCACHED_ACCEL = 2'b10,
		QUAL_EITHER = 2'b11
	} qual_e;

	typedef enum logic [1:0] {
		ACE_READ_ONCE = 2'b00,
		ACE_WRITE_UNIQUE = 2'b01,
		ACE_READ_NOSNOOP = 2'b10,
		ACE_WRITE_NOSNOOP = 2'b11
	} ace_cmd_e;

endpackage

// ==== design/region_if.sv ====
// configuration and request lines between decoder top and one region matcher
`timescale 1ns/1ps
`default_nettype none
interface region_if;
	import region_decode_pkg::*;
	logic en;
	qual_e qual;
	logic [LIMIT_W-1:0] lo;
	logic [LIMIT_W-1:0] hi;
	logic [LIMIT_W-1:0] addr_hi;
	logic uncached;
	logic uncached_accel;
	logic hit;
	modport ctrl (output en, qual, lo, hi, addr_hi, uncached,
		uncached_accel, input hit);
	modport match (input en, qual, lo, hi, addr_hi, uncached,
		uncached_accel, output hit);
endinterface
`default_nettype wire

// ==== design/region_match.sv ====
// address and cache-attribute match of one region
`timescale 1ns/1ps
`default_nettype none
module region_match
	import region_decode_pkg::*;
(
	region_if.match rif
);

	logic in_range;
	logic attr_ok;

	// ************************************************************
	// hit evaluation
	// ************************************************************
	always_comb
	begin
		// inclusive 64 KB granular window
		in_range = (rif.addr_hi >= rif.lo) && (rif.addr_hi <= rif.hi);
		unique case (rif.qual)
			QUAL_ANY: attr_ok = 1'b1;
			QUAL_UNCACHED: attr_ok = rif.uncached;
			QUAL_UNCACHED_ACCEL: attr_ok = rif.uncached_accel;
			QUAL_EITHER: attr_ok = rif.uncached | rif.uncached_accel;
		endcase
		rif.hit = rif.en && in_range && attr_ok;
	end

endmodule
`default_nettype wire
